// ### core/closed_loop_guard_pkg.sv
// Shared constants and types for the closed loop homing and deviation guard
package closed_loop_guard_pkg;

	// ------------------------------------------------------------
	// Register byte offsets on the bus
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_DEV_CFG = 8'h00; // Deviation configuration
	localparam logic [7:0] OFS_SPEED_LEVEL = 8'h04; // Speed level, r/min
	localparam logic [7:0] OFS_POS_LEVEL = 8'h08; // Position level
	localparam logic [7:0] OFS_HOME_CFG = 8'h0c; // Homing configuration
	localparam logic [7:0] OFS_PULSES_PER_REV = 8'h10; // Load pulses/rev
	localparam logic [7:0] OFS_HOME_SHIFT = 8'h14; // Home shift distance
	localparam logic [7:0] OFS_CONTROL = 8'h18; // Command strobes
	localparam logic [7:0] OFS_STATUS = 8'h1c; // Alarm and homing status
	localparam logic [7:0] OFS_HOME_POS = 8'h20; // Captured home position

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CFG_CHECK_LSB = 0; // deviation_check_select [1:0]
	localparam int CFG_METHOD_LSB = 2; // position_check_method [3:2]
	localparam int CFG_RESET_SEL_BIT = 4; // deviation_alarm_reset_select
	localparam int CFG_UNIT_BIT = 5; // position_level_unit_select
	localparam int HCFG_ENC_LSB = 8; // Encoder kind [9:8]
	localparam int HCFG_MARK_BIT = 10; // Linear scale has a reference mark
	localparam int CTL_START_BIT = 0; // Start homing
	localparam int CTL_ALARM_RESET_BIT = 1; // Normal alarm reset
	localparam int CTL_SOFT_RESET_BIT = 2; // Software reset

	// ------------------------------------------------------------
	// Values after reset and limits
	// ------------------------------------------------------------
	localparam logic [1:0] RST_CHECK_SELECT = 2'h3; // Both checks
	localparam logic [1:0] RST_CHECK_METHOD = 2'h0; // Continuous
	localparam logic [15:0] RST_SPEED_LEVEL = 16'h0190; // 400 r/min
	localparam logic [15:0] RST_POS_LEVEL = 16'h0064; // 100 kpulses
	localparam logic [15:0] MIN_LEVEL = 16'h0001; // Lowest level, both
	localparam logic [15:0] MAX_POS_LEVEL = 16'h4e20; // 20000
	localparam logic [31:0] KPULSE = 32'h0000_03e8; // Pulses per kpulse
	localparam logic [31:0] MIN_PPR = 32'h0000_1000; // 2^12 pulses
	localparam logic [31:0] MAX_PPR = 32'h0400_0000; // 2^26 pulses
	localparam logic [31:0] RST_PPR = 32'h0000_1000; // Smallest grid
	localparam logic [5:0] DIV_STEPS = 6'h20; // Modulo steps, 32 bits

	// ------------------------------------------------------------
	// Homing method codes, two's complement
	// ------------------------------------------------------------
	localparam logic [7:0] HM_DOG = 8'hff; // -1 dog type
	localparam logic [7:0] HM_MARK_FWD = 8'h22; // 34
	localparam logic [7:0] HM_MARK_REV = 8'h21; // 33
	localparam logic [7:0] HM_STROKE_REV = 8'hf5; // -11
	localparam logic [7:0] HM_STROKE_FWD = 8'hd5; // -43
	localparam logic [7:0] HM_DATA_SET = 8'h23; // 35 current position

	// ------------------------------------------------------------
	// Enumerations and carriers
	// ------------------------------------------------------------
	localparam logic [1:0] METHOD_CONTINUOUS = 2'h0;
	localparam logic [1:0] METHOD_STOP_ONLY = 2'h1;
	localparam logic [1:0] METHOD_STOP_OR_OFF = 2'h2;
	localparam logic [1:0] ENC_ABS_LINEAR = 2'h0;
	localparam logic [1:0] ENC_INC_LINEAR = 2'h1;
	localparam logic [1:0] ENC_SERIAL_ROTARY = 2'h2;

	typedef struct packed {
		logic signed [15:0] speed; // r/min
		logic signed [31:0] pos; // Load-side pulse units
	} feedback_t;

	typedef struct packed {
		logic speed; // speed_deviation_alarm
		logic position; // position_deviation_alarm
		logic stop_position; // stop_position_deviation_alarm
	} alarm_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} wb_req_t;

endpackage

// ### core/closed_loop_homing_and_deviation_guard.sv
// Load-side homing reference and motor/load deviation guard, Wishbone slave
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Home from load encoder; motor index ignored
// - Absolute scale: grid every revolution from zero
// - Absolute dog homing: next grid after dog
// - Incremental scale: grid from first mark
// - Incremental dog homing: next grid after dog
// - Mark homing: mark plus shift distance
// - Method 33 is 34 reversed
// - Method -43 is -11 reversed
// - No mark on incremental scale: only index-free methods allowed
// - Serial rotary load encoder: home at index
// - Check select: off, speed, position, both
// - Speed difference at level: alarm, stop
// - Speed level from 1, default 400
// - Position difference at level: alarm, stop
// - At command stop: separate stop alarm
// - Method: continuous, stop, stop or off
// - Stop-only method raises only stop alarm
// - Position level 1 to 20000, default 100
// - Unit select: kilopulse or single pulse
// - Reset select: power/soft only, or normal
module closed_loop_homing_and_deviation_guard #(
	parameter logic [15:0] PERMISSIBLE_SPEED = 16'h1770 // Top speed level
) (
	input wire logic clk_i, // Control-cycle clock
	input wire logic rst_i, // Power-on reset
	input wire closed_loop_guard_pkg::wb_req_t wb_req_i, // Bus request
	output logic wb_ack_o, // Bus acknowledge
	output logic [31:0] wb_dat_o, // Bus read data
	input wire closed_loop_guard_pkg::feedback_t motor_fb_i, // After gear
	input wire closed_loop_guard_pkg::feedback_t load_fb_i, // Load encoder
	input wire logic load_mark_i, // Load reference mark or index
	input wire logic dog_i, // Proximity dog, high while on dog
	input wire logic command_zero_i, // Position command is zero
	input wire logic servo_on_i, // Servo is on
	input wire logic alarm_reset_i, // Normal alarm reset pulse
	output closed_loop_guard_pkg::alarm_t alarm_o, // Sticky alarms
	output logic stop_motor_o, // Stop request to the drive
	output logic homing_busy_o, // Homing search in progress
	output logic home_valid_o, // Home position captured
	output logic home_error_o, // Method refused or grid unknown
	output logic home_dir_o, // Search direction, 1 = forward
	output logic signed [31:0] home_pos_o // Home position, load units
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum {H_IDLE, H_DIVIDE, H_DOG_ON, H_DOG_OFF, H_GRID,
		H_MARK} home_state_t;

	home_state_t state; // Homing sequencer state
	home_state_t next_state; // Sequencer next state
	logic [1:0] check_select; // deviation_check_select
	logic [1:0] check_method; // position_check_method
	logic reset_select; // deviation_alarm_reset_select
	logic unit_select; // position_level_unit_select
	logic [15:0] speed_level; // speed_deviation_level
	logic [15:0] pos_level; // position_deviation_level
	logic [7:0] home_method; // Homing method code
	logic [1:0] enc_kind; // Load encoder kind
	logic has_mark; // Linear scale carries a reference mark
	logic [31:0] ppr; // Load pulses per motor revolution
	logic signed [31:0] home_shift; // home_shift_distance
	logic bus_req; // New bus cycle waiting for its ack
	logic wr_en; // Write taken this edge
	logic [31:0] ctl_wr; // Control strobes written this edge
	logic start; // Homing start request
	logic soft_reset; // Software reset request
	logic alarm_clear; // Alarm clear allowed this edge
	logic mark_prev; // Mark level, last cycle
	logic mark_rise; // Mark crossed this cycle
	logic dog_prev; // Dog level, last cycle
	logic dog_fall; // Dog released this cycle
	logic mark_seen; // A mark crossed since power-on
	logic signed [31:0] prev_pos; // Load position, last cycle
	logic [31:0] phase; // Position within the revolution grid
	logic phase_valid; // Grid is anchored
	logic [31:0] next_phase; // Phase after this cycle's motion
	logic wrap_fwd; // Grid point crossed moving forward
	logic wrap_rev; // Grid point crossed moving backward
	logic signed [31:0] grid_pos; // Grid point just crossed
	logic [5:0] div_cnt; // Modulo steps left
	logic [31:0] div_num; // Dividend being shifted out
	logic [31:0] div_rem; // Running remainder
	logic method_known; // Method code supported
	logic needs_index; // Method depends on a mark or index
	logic refuse; // Start request refused
	logic capture; // Home position captured this cycle
	logic signed [31:0] capture_pos; // Position captured, before shift
	logic [16:0] speed_abs; // Speed difference magnitude
	logic [32:0] pos_abs; // Position difference magnitude
	logic [31:0] pos_threshold; // Level in pulses
	logic pos_over; // Position difference at level
	logic stop_window; // Command-stop detection window
	closed_loop_guard_pkg::alarm_t alarm_set; // Alarm events this cycle

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	// One wait state: ack rises the cycle after the request, then drops
	assign bus_req = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	// Writes land at the edge where the master sees ack high
	assign wr_en = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_ack_o;
	assign ctl_wr = (wr_en && wb_req_i.adr == closed_loop_guard_pkg::OFS_CONTROL)
		? merge(32'h0000_0000, wb_req_i.dat, wb_req_i.sel) : 32'h0000_0000;
	assign start = ctl_wr[closed_loop_guard_pkg::CTL_START_BIT];
	assign soft_reset = ctl_wr[closed_loop_guard_pkg::CTL_SOFT_RESET_BIT];

	// Acknowledge every address, mapped or not
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// Read data, registered with the ack; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_req_i.we) begin
			unique case (wb_req_i.adr)
				closed_loop_guard_pkg::OFS_DEV_CFG:
					wb_dat_o <= {26'h0, unit_select, reset_select,
						check_method, check_select};
				closed_loop_guard_pkg::OFS_SPEED_LEVEL:
					wb_dat_o <= {16'h0000, speed_level};
				closed_loop_guard_pkg::OFS_POS_LEVEL:
					wb_dat_o <= {16'h0000, pos_level};
				closed_loop_guard_pkg::OFS_HOME_CFG:
					wb_dat_o <= {21'h0, has_mark, enc_kind, home_method};
				closed_loop_guard_pkg::OFS_PULSES_PER_REV: wb_dat_o <= ppr;
				closed_loop_guard_pkg::OFS_HOME_SHIFT: wb_dat_o <= home_shift;
				closed_loop_guard_pkg::OFS_STATUS:
					wb_dat_o <= {25'h0, mark_seen, homing_busy_o,
						home_error_o, home_valid_o, alarm_o.stop_position,
						alarm_o.position, alarm_o.speed};
				closed_loop_guard_pkg::OFS_HOME_POS: wb_dat_o <= home_pos_o;
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// Deviation configuration; writes go through byte lanes
	always_ff @(posedge clk_i) begin
		logic [31:0] v;
		v = merge({26'h0, unit_select, reset_select, check_method,
			check_select}, wb_req_i.dat, wb_req_i.sel);
		if (rst_i) begin
			check_select <= closed_loop_guard_pkg::RST_CHECK_SELECT;
			check_method <= closed_loop_guard_pkg::RST_CHECK_METHOD;
			reset_select <= 1'b0;
			unit_select <= 1'b0;
		end else if (wr_en &&
			wb_req_i.adr == closed_loop_guard_pkg::OFS_DEV_CFG) begin
			check_select <= v[closed_loop_guard_pkg::CFG_CHECK_LSB +: 2];
			check_method <= v[closed_loop_guard_pkg::CFG_METHOD_LSB +: 2];
			reset_select <= v[closed_loop_guard_pkg::CFG_RESET_SEL_BIT];
			unit_select <= v[closed_loop_guard_pkg::CFG_UNIT_BIT];
		end
	end

	// Levels; out-of-range writes clamp so a zero level never trips
	always_ff @(posedge clk_i) begin
		logic [15:0] s;
		logic [15:0] p;
		s = 16'(merge({16'h0, speed_level}, wb_req_i.dat, wb_req_i.sel));
		p = 16'(merge({16'h0, pos_level}, wb_req_i.dat, wb_req_i.sel));
		if (rst_i) begin
			speed_level <= closed_loop_guard_pkg::RST_SPEED_LEVEL;
			pos_level <= closed_loop_guard_pkg::RST_POS_LEVEL;
		end else if (wr_en) begin
			if (wb_req_i.adr == closed_loop_guard_pkg::OFS_SPEED_LEVEL) begin
				speed_level <= (s < closed_loop_guard_pkg::MIN_LEVEL)
					? closed_loop_guard_pkg::MIN_LEVEL
					: (s > PERMISSIBLE_SPEED) ? PERMISSIBLE_SPEED : s;
			end
			if (wb_req_i.adr == closed_loop_guard_pkg::OFS_POS_LEVEL) begin
				pos_level <= (p < closed_loop_guard_pkg::MIN_LEVEL)
					? closed_loop_guard_pkg::MIN_LEVEL
					: (p > closed_loop_guard_pkg::MAX_POS_LEVEL)
					? closed_loop_guard_pkg::MAX_POS_LEVEL : p;
			end
		end
	end

	// Homing configuration, grid size and shift distance
	always_ff @(posedge clk_i) begin
		logic [31:0] h;
		logic [31:0] g;
		h = merge({21'h0, has_mark, enc_kind, home_method}, wb_req_i.dat,
			wb_req_i.sel);
		g = merge(ppr, wb_req_i.dat, wb_req_i.sel);
		if (rst_i) begin
			home_method <= closed_loop_guard_pkg::HM_DOG;
			enc_kind <= closed_loop_guard_pkg::ENC_ABS_LINEAR;
			has_mark <= 1'b1;
			ppr <= closed_loop_guard_pkg::RST_PPR;
			home_shift <= 32'sh0000_0000;
		end else if (wr_en) begin
			if (wb_req_i.adr == closed_loop_guard_pkg::OFS_HOME_CFG) begin
				home_method <= h[7:0];
				enc_kind <= h[closed_loop_guard_pkg::HCFG_ENC_LSB +: 2];
				has_mark <= h[closed_loop_guard_pkg::HCFG_MARK_BIT];
			end
			if (wb_req_i.adr ==
				closed_loop_guard_pkg::OFS_PULSES_PER_REV) begin
				// Grid must be wider than one cycle of motion
				ppr <= (g < closed_loop_guard_pkg::MIN_PPR)
					? closed_loop_guard_pkg::MIN_PPR
					: (g > closed_loop_guard_pkg::MAX_PPR)
					? closed_loop_guard_pkg::MAX_PPR : g;
			end
			if (wb_req_i.adr == closed_loop_guard_pkg::OFS_HOME_SHIFT) begin
				home_shift <= merge(home_shift, wb_req_i.dat, wb_req_i.sel);
			end
		end
	end

	// ------------------------------------------------------------
	// Load-side edges and revolution grid
	// ------------------------------------------------------------
	// Only the load mark is watched; the motor index has no port
	assign mark_rise = load_mark_i && !mark_prev;
	assign dog_fall = dog_prev && !dog_i;

	// Edge history and first-mark flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mark_prev <= 1'b0;
			dog_prev <= 1'b0;
			mark_seen <= 1'b0;
			prev_pos <= 32'sh0000_0000;
		end else begin
			mark_prev <= load_mark_i;
			dog_prev <= dog_i;
			prev_pos <= load_fb_i.pos;
			if (mark_rise) begin
				mark_seen <= 1'b1;
			end
		end
	end

	// Phase moves by this cycle's delta; motion per cycle is below a rev
	always_comb begin
		logic signed [32:0] sum;
		logic signed [32:0] delta;
		delta = 33'(load_fb_i.pos) - 33'(prev_pos);
		sum = $signed({1'b0, phase}) + delta;
		wrap_fwd = sum >= $signed({1'b0, ppr});
		wrap_rev = sum < 33'sh0;
		if (wrap_fwd) begin
			next_phase = 32'(sum - $signed({1'b0, ppr}));
		end else if (wrap_rev) begin
			next_phase = 32'(sum + $signed({1'b0, ppr}));
		end else begin
			next_phase = sum[31:0];
		end
		grid_pos = wrap_rev ? load_fb_i.pos + $signed(ppr - next_phase)
			: load_fb_i.pos - $signed(next_phase);
	end

	// Grid anchor and tracking
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_reset) begin
			phase <= 32'h0000_0000;
			phase_valid <= 1'b0;
		end else if (state == H_DIVIDE && div_cnt == 6'h00) begin
			phase <= div_rem;
			phase_valid <= 1'b1;
		end else if (enc_kind == closed_loop_guard_pkg::ENC_INC_LINEAR &&
			mark_rise && !mark_seen) begin
			phase <= 32'h0000_0000;
			phase_valid <= 1'b1;
		end else begin
			phase <= next_phase;
		end
	end

	// Restoring modulo of the absolute position; the axis rests meanwhile
	always_ff @(posedge clk_i) begin
		logic [32:0] r;
		r = {div_rem, div_num[31]};
		if (rst_i) begin
			div_cnt <= 6'h00;
			div_num <= 32'h0000_0000;
			div_rem <= 32'h0000_0000;
		end else if (state != H_DIVIDE) begin
			div_cnt <= closed_loop_guard_pkg::DIV_STEPS;
			div_num <= load_fb_i.pos;
			div_rem <= 32'h0000_0000;
		end else if (div_cnt != 6'h00) begin
			div_cnt <= div_cnt - 6'h01;
			div_num <= {div_num[30:0], 1'b0};
			div_rem <= (r >= {1'b0, ppr}) ? 32'(r - {1'b0, ppr}) : r[31:0];
		end
	end

	// ------------------------------------------------------------
	// Homing sequencer
	// ------------------------------------------------------------
	// Method decode
	always_comb begin
		method_known = 1'b1;
		needs_index = 1'b1;
		home_dir_o = 1'b1;
		unique case (home_method)
			closed_loop_guard_pkg::HM_DOG: home_dir_o = 1'b1;
			closed_loop_guard_pkg::HM_MARK_FWD: home_dir_o = 1'b1;
			closed_loop_guard_pkg::HM_MARK_REV: home_dir_o = 1'b0;
			closed_loop_guard_pkg::HM_STROKE_REV: home_dir_o = 1'b0;
			closed_loop_guard_pkg::HM_STROKE_FWD: home_dir_o = 1'b1;
			closed_loop_guard_pkg::HM_DATA_SET: needs_index = 1'b0;
			default: method_known = 1'b0;
		endcase
	end

	// Refuse index methods on a markless incremental scale
	assign refuse = !method_known ||
		enc_kind == 2'h3 ||
		(needs_index && !has_mark &&
		enc_kind == closed_loop_guard_pkg::ENC_INC_LINEAR);

	// Next state and capture point
	always_comb begin
		next_state = state;
		capture = 1'b0;
		capture_pos = load_fb_i.pos;
		unique case (state)
			H_IDLE: begin
				if (start && !refuse) begin
					if (!needs_index) begin
						capture = 1'b1;
					end else if (home_method == closed_loop_guard_pkg::HM_DOG)
						begin
						next_state = (enc_kind ==
							closed_loop_guard_pkg::ENC_ABS_LINEAR)
							? H_DIVIDE : H_DOG_ON;
					end else begin
						next_state = H_MARK;
					end
				end
			end
			H_DIVIDE: begin
				if (div_cnt == 6'h00) begin
					next_state = H_DOG_ON;
				end
			end
			H_DOG_ON: begin
				if (dog_i) begin
					next_state = H_DOG_OFF;
				end
			end
			H_DOG_OFF: begin
				if (dog_fall) begin
					next_state = (enc_kind ==
						closed_loop_guard_pkg::ENC_SERIAL_ROTARY)
						? H_MARK : H_GRID;
				end
			end
			H_GRID: begin
				if (wrap_fwd || wrap_rev) begin
					capture = 1'b1;
					capture_pos = grid_pos;
				end
			end
			H_MARK: begin
				if (mark_rise) begin
					capture = 1'b1;
				end
			end
		endcase
		if (capture) begin
			next_state = H_IDLE;
		end
		if (soft_reset) begin
			next_state = H_IDLE;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= H_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Grid must be anchored when the dog releases
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_reset) begin
			home_error_o <= 1'b0;
		end else if (state == H_IDLE && start) begin
			home_error_o <= refuse;
		end else if (state == H_DOG_OFF && dog_fall &&
			enc_kind != closed_loop_guard_pkg::ENC_SERIAL_ROTARY &&
			!phase_valid) begin
			home_error_o <= 1'b1;
		end
	end

	// Home result; a new start drops the old result
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_reset) begin
			home_valid_o <= 1'b0;
			home_pos_o <= 32'sh0000_0000;
		end else if (capture) begin
			home_valid_o <= 1'b1;
			home_pos_o <= capture_pos + home_shift;
		end else if (state == H_IDLE && start) begin
			home_valid_o <= 1'b0;
		end
	end

	// Busy while the sequencer is away from idle
	assign homing_busy_o = state != H_IDLE;

	// ------------------------------------------------------------
	// Deviation guard
	// ------------------------------------------------------------
	// Magnitudes of both differences
	always_comb begin
		logic signed [16:0] ds;
		logic signed [32:0] dp;
		ds = 17'(motor_fb_i.speed) - 17'(load_fb_i.speed);
		dp = 33'(motor_fb_i.pos) - 33'(load_fb_i.pos);
		speed_abs = ds[16] ? 17'(-ds) : ds;
		pos_abs = dp[32] ? 33'(-dp) : dp;
	end

	assign pos_threshold = unit_select ? {16'h0000, pos_level}
		: 32'({16'h0000, pos_level} * closed_loop_guard_pkg::KPULSE);
	assign pos_over = pos_abs >= {1'b0, pos_threshold};

	assign stop_window = (check_method ==
		closed_loop_guard_pkg::METHOD_STOP_OR_OFF)
		? (!servo_on_i || command_zero_i) : command_zero_i;

	// Alarm events
	always_comb begin
		alarm_set.speed = check_select[0] &&
			speed_abs >= {1'b0, speed_level};
		alarm_set.position = check_select[1] && pos_over && !stop_window &&
			check_method != closed_loop_guard_pkg::METHOD_STOP_ONLY &&
			check_method != closed_loop_guard_pkg::METHOD_STOP_OR_OFF;
		alarm_set.stop_position = check_select[1] && pos_over &&
			stop_window;
	end

	assign alarm_clear = soft_reset || (reset_select && (alarm_reset_i ||
		ctl_wr[closed_loop_guard_pkg::CTL_ALARM_RESET_BIT]));

	// Sticky alarms; a new event beats a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alarm_o <= '0;
		end else begin
			alarm_o <= alarm_set | (alarm_o & {3{!alarm_clear}});
		end
	end

	assign stop_motor_o = |alarm_o;

endmodule

`default_nettype wire

// ### dv/guard_props.sv
// Checker for bus timing and deviation alarms of the guard
`timescale 1ns/1ns
`default_nettype none
module guard_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire closed_loop_guard_pkg::wb_req_t wb_req_i,
	input wire logic wb_ack_o,
	input wire closed_loop_guard_pkg::feedback_t motor_fb_i,
	input wire closed_loop_guard_pkg::feedback_t load_fb_i,
	input wire logic command_zero_i,
	input wire logic servo_on_i,
	input wire logic alarm_reset_i,
	input wire closed_loop_guard_pkg::alarm_t alarm_o,
	input wire logic stop_motor_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Request taken only while no answer is pending
	sequence s_take;
		wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	endsequence
	a_ack_one_later:
	assert property (s_take |=> wb_ack_o) else $error("ack late");
	a_ack_one_wide:
	assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_stop_from_alarm:
	assert property (stop_motor_o == |alarm_o) else $error("stop mismatch");
	a_speed_needs_diff:
	assert property ($rose(alarm_o.speed) |->
		$past(motor_fb_i.speed) != $past(load_fb_i.speed)) else $error("spd");
	a_pos_needs_diff:
	assert property ($rose(alarm_o.position) |->
		$past(motor_fb_i.pos) != $past(load_fb_i.pos)) else $error("pos");
	a_general_not_stop:
	assert property ($rose(alarm_o.position) |-> !$past(command_zero_i))
		else $error("general alarm at stop");
	a_stop_in_window:
	assert property ($rose(alarm_o.stop_position) |->
		$past(command_zero_i) || !$past(servo_on_i)) else $error("stop alarm");
	a_alarm_stays_set:
	assert property (alarm_o.speed && !alarm_reset_i && !wb_req_i.we
		|=> alarm_o.speed) else $error("alarm dropped");
endmodule
bind closed_loop_homing_and_deviation_guard guard_props i_props (.clk_i,
	.rst_i, .wb_req_i, .wb_ack_o, .motor_fb_i, .load_fb_i, .command_zero_i,
	.servo_on_i, .alarm_reset_i, .alarm_o, .stop_motor_o);
`default_nettype wire

// ### dv/motion_ctrl_model.sv
// Motion controller model driving reference mark and proximity dog
`timescale 1ns/1ns
`default_nettype none
module motion_ctrl_model (
	input wire logic clk_i,
	output logic mark_o,
	output logic dog_o
);
	initial begin
		mark_o = 1'b0;
		dog_o = 1'b0;
	end
	task automatic cross_mark();
		dog_o <= 1'b1;
		@(posedge clk_i);
		mark_o <= 1'b1;
		repeat (2) @(posedge clk_i);
		mark_o <= 1'b0;
		dog_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the homing and deviation guard
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	closed_loop_guard_pkg::wb_req_t req = '0;
	closed_loop_guard_pkg::feedback_t mfb = '0, lfb = '0;
	closed_loop_guard_pkg::alarm_t alm;
	logic cz = 1'b0, son = 1'b1, ars = 1'b0;
	logic ack, mark, dog, stop, busy, valid, herr, hdir;
	logic [31:0] rd, q;
	logic signed [31:0] hpos;
	int n_mismatch = 0, comparisons = 0, i;
	always #20 clk_i = ~clk_i;
	closed_loop_homing_and_deviation_guard i_dut (.clk_i, .rst_i,
		.wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rd), .motor_fb_i(mfb),
		.load_fb_i(lfb), .load_mark_i(mark), .dog_i(dog),
		.command_zero_i(cz), .servo_on_i(son), .alarm_reset_i(ars),
		.alarm_o(alm), .stop_motor_o(stop), .homing_busy_o(busy),
		.home_valid_o(valid), .home_error_o(herr), .home_dir_o(hdir),
		.home_pos_o(hpos));
	motion_ctrl_model i_ctrl (.clk_i, .mark_o(mark), .dog_o(dog));
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Classic single cycle; held until ack is sampled
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		int k;
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, w, 4'hf, a, d};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rd;
		req.cyc <= 1'b0;
		req.stb <= 1'b0;
		if (k >= 20) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	task automatic ar();
		ars <= 1'b1;
		step(1);
		ars <= 1'b0;
		step(2);
	endtask
	task automatic t_reset();
		wb(0, 8'h00, 0);
		chk("check_sel", q, 32'h3);
		wb(0, 8'h04, 0);
		chk("speed_lvl", q, 32'd400);
		wb(0, 8'h08, 0);
		chk("pos_lvl", q, 32'd100);
		wb(1, 8'h04, 0);
		wb(0, 8'h04, 0);
		chk("speed_min", q, 32'd1);
		wb(1, 8'h04, 32'd400);
		wb(0, 8'h3c, 0);
		chk("unmapped", q, 0);
		$display("test reset done");
	endtask
	task automatic t_speed();
		wb(1, 8'h00, 32'h11);
		lfb.speed <= 16'sd399;
		step(3);
		chk("spd_below", alm, 0);
		lfb.speed <= 16'sd400;
		step(3);
		chk("spd_alarm", {alm, stop}, 4'h9);
		lfb.speed <= 0;
		ar();
		chk("spd_clear", alm, 0);
		wb(1, 8'h00, 32'h01);
		lfb.speed <= 16'sd500;
		step(3);
		lfb.speed <= 0;
		ar();
		chk("no_clear", alm, 3'h4);
		wb(1, 8'h18, 32'h4);
		step(2);
		chk("soft_clear", alm, 0);
		$display("test speed done");
	endtask
	task automatic t_pos();
		wb(1, 8'h08, 32'h5);
		wb(1, 8'h00, 32'h32);
		lfb.pos <= 32'sd4;
		step(3);
		chk("pos_below", alm, 0);
		lfb.pos <= 32'sd5;
		step(3);
		chk("pos_alarm", alm, 3'h2);
		lfb.pos <= 0;
		ar();
		cz <= 1'b1;
		lfb.pos <= 32'sd5;
		step(3);
		chk("stop_alarm", alm, 3'h1);
		lfb.pos <= 0;
		ar();
		wb(1, 8'h00, 32'h36);
		cz <= 1'b0;
		lfb.pos <= 32'sd5;
		step(3);
		chk("stop_only", alm, 0);
		wb(1, 8'h00, 32'h3a);
		son <= 1'b0;
		step(3);
		chk("servo_off", alm, 3'h1);
		lfb.pos <= 0;
		ar();
		$display("test position done");
	endtask
	task automatic t_home();
		wb(1, 8'h0c, 32'h522);
		wb(1, 8'h14, 32'd10);
		lfb.pos <= 32'sd1000;
		mfb.pos <= 32'sd1000;
		wb(1, 8'h18, 32'h1);
		i_ctrl.cross_mark();
		for (i = 0; i < 20 && valid !== 1'b1; i++) step(1);
		chk("valid", valid, 1);
		chk("home_pos", hpos, 32'd1010);
		chk("dir_34", hdir, 1);
		wb(1, 8'h0c, 32'h521);
		step(1);
		chk("dir_33", hdir, 0);
		// Dog homing on the grid anchored at the first mark (pos 1000)
		wb(1, 8'h0c, 32'h5ff);
		wb(1, 8'h18, 32'h1);
		i_ctrl.cross_mark();
		chk("busy", busy, 1);
		step(2);
		lfb.pos <= 32'sd3000;
		mfb.pos <= 32'sd3000;
		step(1);
		lfb.pos <= 32'sd5196;
		mfb.pos <= 32'sd5196;
		for (i = 0; i < 20 && valid !== 1'b1; i++) step(1);
		chk("dog_home", hpos, 32'd5106);
		chk("idle", busy, 0);
		wb(1, 8'h0c, 32'h122);
		wb(1, 8'h18, 32'h1);
		step(1);
		chk("no_mark", herr, 1);
		$display("test homing done");
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_speed();
		t_pos();
		t_home();
		finish_test();
	end
endmodule
`default_nettype wire
